// ---- pps_input_select.sv ----
// Input pin selector for timer clock and third SPI port inputs
//
// Summary of operation
// - SPI clock picked by bits fourteen to eight
// - SPI slave select from separate register
// - Code zero gives constant low
// - Code one gives comparator one output
// - SPI top code pin 124; timer 1111100
// - Other bits ignore writes, read zero
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pps_input_select #(
  parameter int NUM_PINS = 125
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // APB slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Sources
  input  wire logic [NUM_PINS-1:0] pin_i,
  input  wire logic                comparator_one_output_i,
  // Routed peripheral inputs
  output logic                     timer_b_external_clock_input_o,
  output logic                     spi_c_clock_input_o,
  output logic                     spi_c_data_input_o,
  output logic                     spi_c_slave_select_input_o
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // One pin per code up to the top pin, no more and no less
  if (NUM_PINS != pps_pkg::PPS_PIN_TOP + 1) begin : g_bad_pins
    $error("NUM_PINS must be 125");
  end

  // Selector fields are seven bits wide
  if (pps_pkg::PPS_SEL_W != 7) begin : g_bad_width
    $error("selector width must be 7");
  end

  // Both fields of the shared register fit in sixteen bits
  if (pps_pkg::PPS_HI_POS + pps_pkg::PPS_SEL_W > 16) begin : g_bad_hi
    $error("high field does not fit");
  end

  // Low field must end below the high field
  if (pps_pkg::PPS_LO_POS + pps_pkg::PPS_SEL_W > pps_pkg::PPS_HI_POS)
  begin : g_bad_lo
    $error("selector fields overlap");
  end

  // Top pin must be reachable by a selector code
  if (pps_pkg::PPS_PIN_TOP >= (1 << pps_pkg::PPS_SEL_W)) begin : g_bad_top
    $error("top pin beyond selector range");
  end

  // Timer list ends at or below the SPI list
  if (pps_pkg::PPS_CODE_TMR_TOP > pps_pkg::PPS_CODE_SPI_TOP)
  begin : g_bad_order
    $error("timer top above SPI top");
  end

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [NUM_PINS-1:0] s1_q;
  logic [NUM_PINS-1:0] s2_q;
  logic [NUM_PINS-1:0] s3_q;
  logic [NUM_PINS-1:0] pin_ok_q;
  logic [2:0]          cmp_s_q;
  logic                cmp_ok_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      cmp_s_q  <= 3'h0;
      cmp_ok_q <= 1'b0;
    end else begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      cmp_s_q <= {cmp_s_q[1:0], comparator_one_output_i};
      if (cmp_s_q[1] == cmp_s_q[2]) begin
        cmp_ok_q <= cmp_s_q[2];
      end
    end
  end

  // Change counts once stages two and three agree
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pin_ok_q[g] <= 1'b0;
      end else if (s2_q[g] == s3_q[g]) begin
        pin_ok_q[g] <= s3_q[g];
      end
    end
  end

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [6:0]  tmr_sel;
    logic [6:0]  sck_sel;
    logic [6:0]  sdi_sel;
    logic [6:0]  ss_sel;
    logic [31:0] rdata;
    logic        ready;
    logic        tmr_out;
    logic        sck_out;
    logic        sdi_out;
    logic        ss_out;
  } pps_state_type;

  pps_state_type st_q;
  pps_state_type st_d;

  // ==========================================================
  // Address decode
  // ==========================================================
  logic setup;
  logic access;
  logic wr;
  logic hit_tmr;
  logic hit_cd;
  logic hit_ss;

  // Setup cycle launches the registered answer
  assign setup   = psel_i && !penable_i;
  // Access cycle in which pready is high
  assign access  = psel_i && penable_i && st_q.ready;
  assign wr      = access && pwrite_i;
  assign hit_tmr = paddr_i == pps_pkg::PPS_OFF_TMR;
  assign hit_cd  = paddr_i == pps_pkg::PPS_OFF_SPI_CD;
  assign hit_ss  = paddr_i == pps_pkg::PPS_OFF_SPI_SS;

  // ==========================================================
  // Write enables
  // ==========================================================
  // Unmapped addresses match none, so writes there are lost
  logic wr_tmr;
  logic wr_cd;
  logic wr_ss;

  assign wr_tmr = wr && hit_tmr;
  assign wr_cd  = wr && hit_cd;
  assign wr_ss  = wr && hit_ss;

  // ==========================================================
  // Write data fields
  // ==========================================================
  // Only selector bits are kept, the rest dropped
  logic [6:0] wr_lo;
  logic [6:0] wr_hi;

  assign wr_lo = pwdata_i[pps_pkg::PPS_LO_POS +: 7];
  assign wr_hi = pwdata_i[pps_pkg::PPS_HI_POS +: 7];

  // ==========================================================
  // Read data
  // ==========================================================
  logic [31:0] rd_tmr;
  logic [31:0] rd_cd;
  logic [31:0] rd_ss;
  logic [31:0] rd_word;

  // Bits outside the fields read as zero
  assign rd_tmr = {25'h0, st_q.tmr_sel};
  assign rd_cd  = {17'h0, st_q.sck_sel, 1'b0, st_q.sdi_sel};
  assign rd_ss  = {25'h0, st_q.ss_sel};

  // Unmapped addresses read as zero
  always_comb begin
    rd_word = 32'h0;
    if (hit_tmr) begin
      rd_word = rd_tmr;
    end
    if (hit_cd) begin
      rd_word = rd_cd;
    end
    if (hit_ss) begin
      rd_word = rd_ss;
    end
  end

  // ==========================================================
  // Source routing
  // ==========================================================
  localparam int NUM_ROUTES = 4;

  logic [6:0]            route_sel [NUM_ROUTES];
  logic [6:0]            route_top [NUM_ROUTES];
  wire  [NUM_ROUTES-1:0] route_val;

  // Slot order: timer, spi clock, spi data, spi select
  always_comb begin
    route_sel[0] = st_q.tmr_sel;
    route_sel[1] = st_q.sck_sel;
    route_sel[2] = st_q.sdi_sel;
    route_sel[3] = st_q.ss_sel;
    route_top[0] = pps_pkg::PPS_CODE_TMR_TOP;
    route_top[1] = pps_pkg::PPS_CODE_SPI_TOP;
    route_top[2] = pps_pkg::PPS_CODE_SPI_TOP;
    route_top[3] = pps_pkg::PPS_CODE_SPI_TOP;
  end

  // Code 0 ground, 1 comparator, top pin 124, else pin n
  // Codes with no pin behind them give a steady low
  for (genvar r = 0; r < NUM_ROUTES; r++) begin : g_route
    logic [6:0] code;
    logic [6:0] top;
    logic       val;

    assign code = route_sel[r];
    assign top  = route_top[r];

    always_comb begin
      val = 1'b0;
      if (code == pps_pkg::PPS_CODE_VSS) begin
        val = 1'b0;
      end else if (code == pps_pkg::PPS_CODE_CMP) begin
        val = cmp_ok_q;
      end else if (code == top) begin
        val = pin_ok_q[pps_pkg::PPS_PIN_TOP];
      end else if (code < top && code < NUM_PINS) begin
        val = pin_ok_q[code];
      end
    end

    assign route_val[r] = val;
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_d       = st_q;
    st_d.ready = setup;
    if (setup) begin
      st_d.rdata = rd_word;
    end
    if (wr_tmr) begin
      st_d.tmr_sel = wr_lo;
    end
    if (wr_cd) begin
      st_d.sck_sel = wr_hi;
      st_d.sdi_sel = wr_lo;
    end
    if (wr_ss) begin
      st_d.ss_sel = wr_lo;
    end
    st_d.tmr_out = route_val[0];
    st_d.sck_out = route_val[1];
    st_d.sdi_out = route_val[2];
    st_d.ss_out  = route_val[3];
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Every selector clears to the ground code

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '{tmr_sel: pps_pkg::PPS_SEL_RESET,
                sck_sel: pps_pkg::PPS_SEL_RESET,
                sdi_sel: pps_pkg::PPS_SEL_RESET,
                ss_sel:  pps_pkg::PPS_SEL_RESET,
                rdata:   32'h0,
                default: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // All outputs except pslverr_o, tied low, come straight from the state register
  assign prdata_o                       = st_q.rdata;
  assign pready_o                       = st_q.ready;
  assign pslverr_o                      = 1'b0;
  assign timer_b_external_clock_input_o = st_q.tmr_out;
  assign spi_c_clock_input_o            = st_q.sck_out;
  assign spi_c_data_input_o             = st_q.sdi_out;
  assign spi_c_slave_select_input_o     = st_q.ss_out;

endmodule : pps_input_select
`default_nettype wire

// ---- pps_pkg.sv ----
// Package with register map and selector codes for the input pin selector
package pps_pkg;
  localparam int          PPS_SEL_W        = 7;
  localparam logic [11:0] PPS_OFF_TMR      = 12'h000;
  localparam logic [11:0] PPS_OFF_SPI_CD   = 12'h004;
  localparam logic [11:0] PPS_OFF_SPI_SS   = 12'h008;
  localparam int          PPS_LO_POS       = 0;
  localparam int          PPS_HI_POS       = 8;
  localparam logic [6:0]  PPS_SEL_RESET    = 7'h00;
  localparam logic [6:0]  PPS_CODE_VSS     = 7'h00;
  localparam logic [6:0]  PPS_CODE_CMP     = 7'h01;
  localparam logic [6:0]  PPS_CODE_TMR_TOP = 7'h7c;
  localparam logic [6:0]  PPS_CODE_SPI_TOP = 7'h7f;
  localparam int          PPS_PIN_TOP      = 124;
endpackage : pps_pkg

// ---- pps_input_select_monitor.sv ----
// Port assertions for the input pin selector
`timescale 1ns/1ps
`default_nettype none
module pps_input_select_monitor (
  input wire logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o,
  input wire logic pslverr_o, spi_c_clock_input_o, spi_c_data_input_o,
  input wire logic timer_b_external_clock_input_o,
  input wire logic spi_c_slave_select_input_o,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i, prdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_s; pready_o && !pwrite_i; endsequence
  sequence wr0_s; pready_o && pwrite_i && paddr_i == 12'h000; endsequence
  ready_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready");
  pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  no_err_a: assert property (!pslverr_o)
    else $error("slave error");
  rd_zero_a: assert property (rd_s |-> !prdata_o[31:15] && !prdata_o[7])
    else $error("spare bits set");
  tmr_rd_a: assert property (rd_s ##0 paddr_i == 12'h000 |-> !prdata_o[31:7])
    else $error("timer bits");
  ss_rd_a: assert property (rd_s ##0 paddr_i == 12'h008 |-> !prdata_o[31:7])
    else $error("select bits");
  rst_low_a: assert property ($rose(rst_n_i) |-> !(spi_c_clock_input_o ||
    spi_c_data_input_o || spi_c_slave_select_input_o ||
    timer_b_external_clock_input_o)) else $error("outputs after reset");
  tmr_vss_a: assert property (wr0_s ##0 !pwdata_i[6:0] |-> ##2
    !timer_b_external_clock_input_o) else $error("timer not low");
endmodule : pps_input_select_monitor
`default_nettype wire

// ---- pps_pins_model.sv ----
// Model of the remappable pins and the comparator
`timescale 1ns/1ps
`default_nettype none
module pps_pins_model (
  input wire logic clk_i,
  input wire logic [6:0] hot_i,
  input wire logic cmp_i,
  output logic [124:0] pin_o,
  output logic cmp_o
);
  // One pin high, all others low
  always_ff @(posedge clk_i) begin
    pin_o <= 125'h1 << hot_i;
    cmp_o <= cmp_i;
  end
endmodule : pps_pins_model
`default_nettype wire

// ---- pps_input_select_tb.sv ----
// Self-checking bench for the input pin selector
`timescale 1ns/1ps
`default_nettype none
module pps_input_select_tb;
  logic clk_i = 1'h0, rst_n_i = 1'h0, sel = 1'h0, en = 1'h0, wr = 1'h0;
  logic cmp = 1'h0, cw, rdy, ok, err;
  logic [6:0] hot = 7'h05;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0, rd, r;
  logic [124:0] pins;
  logic [3:0] outs;
  int errors = 0, cmp_count = 0;
  initial forever #2.5 clk_i = ~clk_i;
  pps_pins_model u_pins (.clk_i(clk_i), .hot_i(hot), .cmp_i(cmp),
    .pin_o(pins), .cmp_o(cw));
  pps_input_select DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(sel),
    .penable_i(en), .pwrite_i(wr), .paddr_i(adr), .pwdata_i(wd),
    .prdata_o(rd), .pready_o(rdy), .pslverr_o(err), .pin_i(pins),
    .comparator_one_output_i(cw), .timer_b_external_clock_input_o(outs[0]),
    .spi_c_clock_input_o(outs[1]), .spi_c_data_input_o(outs[2]),
    .spi_c_slave_select_input_o(outs[3]));
  task automatic summarize();
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    sel <= 1'h1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk_i) en <= 1'h1;
    @(posedge clk_i);
    while (rdy !== 1'h1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 20) begin
      errors++;
      summarize();
    end
    r = rd;
    sel <= 1'h0;
    en <= 1'h0;
    @(posedge clk_i);
  endtask : apb
  task automatic t_regs();
    logic [31:0] ex[4] = '{32'h7f, 32'h7f7f, 32'h7f, 32'h0};
    chk("outs", 32'(outs), 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, 12'(4 * i), 32'h0);
      chk("reset", r, 32'h0);
      chk("slverr", 32'(err), 32'h0);
      apb(1'h1, 12'(4 * i), 32'hffffffff);
      apb(1'h0, 12'(4 * i), 32'h0);
      chk("field", r, ex[i]);
    end
  endtask : t_regs
  task automatic t_route();
    logic [6:0] cd[7] = '{7'h00, 7'h01, 7'h02, 7'h40, 7'h7b, 7'h7c, 7'h7f};
    logic [6:0] top;
    for (int m = 0; m < 2; m++)
      for (int k = 0; k < 4; k++)
        for (int j = 0; j < 7; j++) begin
          top = k == 0 ? pps_pkg::PPS_CODE_TMR_TOP : pps_pkg::PPS_CODE_SPI_TOP;
          ok = cd[j] != 7'h00 && cd[j] <= top && m == 1;
          cmp <= m[0];
          hot <= m == 0 ? 7'h05 : cd[j] >= 7'h7c ? 7'h7c : cd[j];
          apb(1'h1, k == 0 ? 12'h000 : k == 3 ? 12'h008 : 12'h004,
            32'(cd[j]) << (k == 1 ? 8 : 0));
          repeat (8) @(posedge clk_i);
          chk("route", 32'(outs[k]), 32'(ok));
        end
  endtask : t_route
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    t_regs();
    t_route();
    summarize();
  end
endmodule : pps_input_select_tb
bind pps_input_select pps_input_select_monitor u_mon (.*);
`default_nettype wire
